// [core/acrc_pkg.sv]
/*
 * Shared constants and types of the continuous result read block:
 * register offsets, control field positions, reset values and timing.
 * Assumes a 40 MHz system clock that also serves as master clock.
 */
package acrc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [4:0]  OFS_CONTROL   = 5'h00;   // Converter control
	localparam logic [4:0]  OFS_IRQ_STAT  = 5'h04;   // Sticky event status
	localparam logic [4:0]  OFS_IRQ_MASK  = 5'h08;   // Event mask
	localparam logic [4:0]  OFS_MODE      = 5'h0c;   // Buffer enable and live state
	localparam logic [4:0]  OFS_RESULT    = 5'h10;   // Last coded result

	// ----------------------------------------------------------------
	// Converter control fields
	// ----------------------------------------------------------------
	localparam int          CTRL_BIPOLAR  = 14;      // Output coding select
	localparam int          CTRL_CONT     = 11;      // Repeat result read enable
	localparam int          CTRL_CSEN     = 9;       // Chip select function enable
	localparam int          CTRL_INTREF   = 8;       // Internal reference enable
	localparam int          CTRL_REFVAL   = 3;       // Reference level select
	localparam int          CTRL_DDEL     = 2;       // Output disable delay select
	localparam logic [15:0] CTRL_RESET    = 16'h4000;
	localparam logic [15:0] CTRL_WMASK    = 16'h4b0c; // Writable bits

	// ----------------------------------------------------------------
	// Event bits of status and mask
	// ----------------------------------------------------------------
	localparam int          EV_NEW        = 0;       // New result ready
	localparam int          EV_ABANDON    = 1;       // Transfer abandoned
	localparam int          EV_EXIT       = 2;       // Continuous read left
	localparam int          EV_BITS       = 3;
	localparam logic [2:0]  MASK_RESET    = 3'h0;

	// ----------------------------------------------------------------
	// Codes, counts and times
	// ----------------------------------------------------------------
	localparam int          RES_BITS      = 16;      // Result width
	localparam logic [15:0] CODE_MID      = 16'h8000;
	localparam logic [15:0] CODE_FULL     = 16'hffff;
	localparam logic [15:0] CODE_ZERO     = 16'h0000;
	localparam logic [7:0]  EXIT_CMD      = 8'h42;   // Read-data command byte
	localparam logic [6:0]  SWRST_ONES    = 7'h40;   // 64 ones reset
	localparam int          ABANDON_LEAD  = 4;       // Cycles before conversion
	localparam int          CLK_PERIOD_NS = 25;
	localparam int          DIS_SHORT_NS  = 10;
	localparam int          DIS_LONG_NS   = 100;
	localparam logic [2:0]  DIS_SHORT_CYC =
		3'((DIS_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0]  DIS_LONG_CYC  =
		3'((DIS_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Serial pins that cross into the clock domain together
	typedef struct packed {
		logic sclk;
		logic din;
		logic cs_n;
	} acrc_link_type;

	// Link states
	typedef enum logic [1:0] {
		LNK_IDLE,
		LNK_SHIFT,
		LNK_HOLD
	} acrc_lnk_type;

endpackage : acrc_pkg

// [core/acrc_sync.sv]
/*
 * Two flip-flop synchroniser for a group of pin levels.
 * Assumes inputs are asynchronous levels; only stage two is read.
 */
`timescale 1ns/10ps
module acrc_sync #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;   // First stage, read only by q

	// ----------------------------------------------------------------
	// Both stages reset to idle-high levels of the serial pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '1;
			q      <= '1;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : acrc_sync

// [core/acrc_coder.sv]
/*
 * Result coder: turns a two's complement conversion into offset
 * binary or straight binary output code.
 * Assumes the sample spans the bipolar input range.
 */
`timescale 1ns/10ps
module acrc_coder (
	input  wire logic signed [15:0] sample,
	input  wire logic               bipolar,
	output logic             [15:0] code
);

	// ----------------------------------------------------------------
	// Coding select
	// ----------------------------------------------------------------
	always_comb begin
		if (bipolar) begin
			// Offset binary: zero to mid code, minus full scale to zero
			code = {~sample[15], sample[14:0]};
		end else if (sample[15]) begin
			// Below zero clamps; unipolar span starts at zero
			code = acrc_pkg::CODE_ZERO;
		end else begin
			// Positive span doubled so full scale reaches all ones
			code = {sample[14:0], sample[14]};
		end
	end

endmodule : acrc_coder

// [core/acrc_top.sv]
/*
 * Continuous result read control: converter control register,
 * conversion timing, data ready framing and serial result shifting,
 * with an Avalon-MM slave and an interrupt.
 * Assumes SYS_CLK is the master clock; serial pins are asynchronous,
 * serial clock idles high, bits change on falling and are sampled
 * on rising edges.
 */
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
// Notes on behaviour
// - Bipolar: zero gives mid code, minus full scale gives zero
// - Bipolar default; clear gives straight binary coding
// - Reference select bit: 2.5 V or 1.25 V
// - Disable delay bit: 10 ns or 100 ns
// - Disable delay used only in three-wire mode
// - Three-wire interface resets on last rising edge
// - Repeat read enable bit 11, reset off
// - Data ready frames each result transfer
// - Clocks ignored until data ready is low
// - Late transfer abandoned four cycles before conversion
// - Sixty-four ones or read command ends mode
// - Exit command needs no checksum byte
// - Buffer enabled forces repeat read off
`timescale 1ns/10ps
module acrc_top #(
	parameter int CONV_PERIOD = 1000   // Master clocks per conversion
) (
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic [15:0] CONV_SAMPLE,
	input  wire logic        SCLK_PIN,
	input  wire logic        DIN_PIN,
	input  wire logic        CS_N_PIN,
	output logic             DOUT_O,
	output logic             DOUT_OE,
	output logic             DRDY_N,
	output logic             IRQ,
	output logic             REF_LEVEL_SEL,
	output logic             INT_REF_EN
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam logic [15:0] CONV_LAST = 16'(CONV_PERIOD - 1);
	localparam logic [15:0] ABANDON_AT = 16'(CONV_PERIOD - 1 - acrc_pkg::ABANDON_LEAD);
	localparam logic [4:0]  LAST_BIT   = 5'(acrc_pkg::RES_BITS - 1);

	acrc_pkg::acrc_link_type link_raw;     // Pins into the synchroniser
	acrc_pkg::acrc_link_type link_s;       // Synchronised pins
	acrc_pkg::acrc_lnk_type  state_r;      // Link state
	logic [15:0]             ctrl_r;       // Converter control
	logic [2:0]              stat_r;       // Sticky events
	logic [2:0]              mask_r;       // Event mask
	logic                    fifo_en_r;    // Result buffer enable
	logic [15:0]             result_r;     // Coded result
	logic [15:0]             code;         // Coder output
	logic [15:0]             conv_cnt_r;   // Conversion timer
	logic [15:0]             shreg_r;      // Result shifter
	logic [4:0]              bit_cnt_r;    // Rising edges in frame
	logic [2:0]              hold_cnt_r;   // Output disable delay
	logic                    sclk_p_r;     // Previous serial clock
	logic                    cs_p_r;       // Previous chip select
	logic [6:0]              ones_cnt_r;   // Consecutive ones seen
	logic [7:0]              cmd_r;        // Command byte shifter
	logic [2:0]              cmd_bit_r;    // Command bit position
	logic                    exit_p_r;     // Exit command seen
	logic                    swrst_p_r;    // Software reset seen
	logic                    abandon_p_r;  // Transfer abandoned
	logic [31:0]             rdata_nxt;    // Read mux
	logic [4:0]              addr_w;       // Word-aligned address
	logic                    wr_take;      // Write takes effect
	logic                    rd_take;      // Read completes
	logic                    conv_done;    // Conversion completes
	logic                    abandon_pt;   // Abandon check moment
	logic                    cont_active;  // Repeat read live
	logic                    cs_en;        // Four-wire mode
	logic                    lnk_open;     // Clocks count (cs low or 3-wire)
	logic                    sclk_rise;    // Serial clock rising
	logic                    sclk_fall;    // Serial clock falling
	logic                    cs_rise;      // Chip select released
	logic                    frame_done;   // Last rising edge of result
	logic                    cmd_byte;     // Eighth command bit now
	logic                    byte_is_exit; // Completed byte is the exit

	assign link_raw    = '{sclk: SCLK_PIN, din: DIN_PIN, cs_n: CS_N_PIN};
	assign addr_w      = {AVS_ADDRESS[4:2], 2'b00};
	assign wr_take     = AVS_WRITE && !AVS_WAITREQUEST;
	assign rd_take     = AVS_READ && !AVS_WAITREQUEST;
	assign cont_active = ctrl_r[acrc_pkg::CTRL_CONT] && !fifo_en_r;
	assign cs_en       = ctrl_r[acrc_pkg::CTRL_CSEN];
	assign lnk_open    = !cs_en || !link_s.cs_n;
	assign sclk_rise   = link_s.sclk && !sclk_p_r && lnk_open;
	assign sclk_fall   = !link_s.sclk && sclk_p_r && lnk_open;
	assign cs_rise     = link_s.cs_n && !cs_p_r;
	assign conv_done   = (conv_cnt_r == CONV_LAST);
	assign abandon_pt  = (conv_cnt_r == ABANDON_AT);
	assign frame_done  = (state_r == acrc_pkg::LNK_SHIFT) && sclk_rise
		&& (bit_cnt_r == LAST_BIT);
	assign cmd_byte     = sclk_rise && (cmd_bit_r == 3'h7);
	assign byte_is_exit = ({cmd_r[6:0], link_s.din} == acrc_pkg::EXIT_CMD);

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	acrc_sync #(.W(3)) u_sync (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.d     (link_raw),
		.q     (link_s)
	);

	acrc_coder u_coder (
		.sample  (CONV_SAMPLE),
		.bipolar (ctrl_r[acrc_pkg::CTRL_BIPOLAR]),
		.code    (code)
	);

	// ----------------------------------------------------------------
	// Avalon slave
	// ----------------------------------------------------------------
	// Read mux; unmapped words read as zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (addr_w == acrc_pkg::OFS_CONTROL) begin
			rdata_nxt = {16'h0000, ctrl_r};
		end else if (addr_w == acrc_pkg::OFS_IRQ_STAT) begin
			rdata_nxt = {29'h0000_0000, stat_r};
		end else if (addr_w == acrc_pkg::OFS_IRQ_MASK) begin
			rdata_nxt = {29'h0000_0000, mask_r};
		end else if (addr_w == acrc_pkg::OFS_MODE) begin
			rdata_nxt = {29'h0000_0000, DRDY_N, cont_active, fifo_en_r};
		end else if (addr_w == acrc_pkg::OFS_RESULT) begin
			rdata_nxt = {16'h0000, result_r};
		end
	end

	// One wait cycle per access keeps read data registered
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0000_0000;
		end else begin
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
			if (AVS_READ && AVS_WAITREQUEST) begin
				AVS_READDATA <= rdata_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// Converter control register
	// ----------------------------------------------------------------
	// Serial exit overrides a bus write in the same cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_r <= acrc_pkg::CTRL_RESET;
		end else if (swrst_p_r) begin
			ctrl_r <= acrc_pkg::CTRL_RESET;
		end else begin
			if (wr_take && addr_w == acrc_pkg::OFS_CONTROL) begin
				if (AVS_BYTEENABLE[0]) begin
					ctrl_r[7:0] <= AVS_WRITEDATA[7:0] & acrc_pkg::CTRL_WMASK[7:0];
				end
				if (AVS_BYTEENABLE[1]) begin
					ctrl_r[15:8] <= AVS_WRITEDATA[15:8] & acrc_pkg::CTRL_WMASK[15:8];
				end
			end
			if (exit_p_r) begin
				ctrl_r[acrc_pkg::CTRL_CONT] <= 1'b0;
			end
		end
	end

	// Mask and result buffer enable; a software reset drops the buffer
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_r    <= acrc_pkg::MASK_RESET;
			fifo_en_r <= 1'b0;
		end else if (swrst_p_r) begin
			fifo_en_r <= 1'b0;
		end else if (wr_take && AVS_BYTEENABLE[0]) begin
			if (addr_w == acrc_pkg::OFS_IRQ_MASK) begin
				mask_r <= AVS_WRITEDATA[2:0];
			end else if (addr_w == acrc_pkg::OFS_MODE) begin
				fifo_en_r <= AVS_WRITEDATA[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			stat_r <= 3'h0;
		end else begin
			stat_r <= (stat_r & ~((wr_take && AVS_BYTEENABLE[0]
				&& addr_w == acrc_pkg::OFS_IRQ_STAT) ? AVS_WRITEDATA[2:0] : 3'h0))
				| {exit_p_r, abandon_p_r, conv_done};
		end
	end

	// Level interrupt and reference outputs, all registered
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ           <= 1'b0;
			REF_LEVEL_SEL <= 1'b0;
			INT_REF_EN    <= 1'b0;
		end else begin
			IRQ           <= |(stat_r & mask_r);
			REF_LEVEL_SEL <= ctrl_r[acrc_pkg::CTRL_REFVAL];
			INT_REF_EN    <= ctrl_r[acrc_pkg::CTRL_INTREF];
		end
	end

	// ----------------------------------------------------------------
	// Conversion timing and data ready
	// ----------------------------------------------------------------
	// Free-running conversion timer; result captured at its wrap
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			conv_cnt_r <= 16'h0000;
			result_r   <= 16'h0000;
		end else begin
			conv_cnt_r <= conv_done ? 16'h0000 : conv_cnt_r + 16'h0001;
			if (conv_done) begin
				result_r <= code;
			end
		end
	end

	// New result pulls data ready low; a fresh result beats its release
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			DRDY_N <= 1'b1;
		end else if (conv_done) begin
			DRDY_N <= 1'b0;
		end else if (frame_done || abandon_p_r
			|| (rd_take && addr_w == acrc_pkg::OFS_RESULT)) begin
			DRDY_N <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Serial result link
	// ----------------------------------------------------------------
	// Edge history of the synchronised serial pins
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_p_r <= 1'b1;
			cs_p_r   <= 1'b1;
		end else begin
			sclk_p_r <= link_s.sclk;
			cs_p_r   <= link_s.cs_n;
		end
	end

	// Frame state, shifter and output drive
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r     <= acrc_pkg::LNK_IDLE;
			shreg_r     <= 16'h0000;
			bit_cnt_r   <= 5'h00;
			hold_cnt_r  <= 3'h0;
			DOUT_O      <= 1'b1;
			DOUT_OE     <= 1'b0;
			abandon_p_r <= 1'b0;
		end else begin
			abandon_p_r <= 1'b0;
			case (state_r)
				acrc_pkg::LNK_IDLE: begin
					// Four-wire idle shows data ready on the data pin
					DOUT_O  <= DRDY_N;
					DOUT_OE <= cont_active && cs_en && !link_s.cs_n;
					bit_cnt_r <= 5'h00;
					// Clocks count only while a result waits
					if (cont_active && !DRDY_N && sclk_fall) begin
						state_r <= acrc_pkg::LNK_SHIFT;
						DOUT_O  <= result_r[15];
						DOUT_OE <= 1'b1;
						shreg_r <= {result_r[14:0], 1'b0};
					end
				end
				acrc_pkg::LNK_SHIFT: begin
					if (!cont_active || (cs_en && cs_rise)) begin
						// Mode left or four-wire frame cut by chip select
						state_r <= acrc_pkg::LNK_IDLE;
						DOUT_OE <= 1'b0;
					end else if (abandon_pt) begin
						// Too close to the next result; give it up
						state_r     <= acrc_pkg::LNK_IDLE;
						DOUT_OE     <= 1'b0;
						abandon_p_r <= 1'b1;
					end else if (frame_done) begin
						if (cs_en) begin
							state_r <= acrc_pkg::LNK_IDLE;
						end else begin
							// Three-wire: reset on last rising edge, then delay
							state_r    <= acrc_pkg::LNK_HOLD;
							hold_cnt_r <= ctrl_r[acrc_pkg::CTRL_DDEL] ?
								acrc_pkg::DIS_LONG_CYC : acrc_pkg::DIS_SHORT_CYC;
						end
					end else begin
						if (sclk_rise) begin
							bit_cnt_r <= bit_cnt_r + 5'h01;
						end
						if (sclk_fall) begin
							DOUT_O  <= shreg_r[15];
							shreg_r <= {shreg_r[14:0], 1'b0};
						end
					end
				end
				acrc_pkg::LNK_HOLD: begin
					// Keep driving the last bit until the delay runs out
					if (hold_cnt_r == 3'h1) begin
						state_r <= acrc_pkg::LNK_IDLE;
						DOUT_OE <= 1'b0;
					end else begin
						hold_cnt_r <= hold_cnt_r - 3'h1;
					end
				end
				default: begin
					state_r <= acrc_pkg::LNK_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Exit command watcher
	// ----------------------------------------------------------------
	// Byte lock is kept across frames because a result is two bytes, but a
	// four-wire chip select release restarts it; no checksum byte is awaited after the exit command
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ones_cnt_r <= 7'h00;
			cmd_r      <= 8'h00;
			cmd_bit_r  <= 3'h0;
			exit_p_r   <= 1'b0;
			swrst_p_r  <= 1'b0;
		end else begin
			exit_p_r  <= cmd_byte && byte_is_exit && cont_active;
			swrst_p_r <= sclk_rise && link_s.din
				&& (ones_cnt_r == acrc_pkg::SWRST_ONES - 7'h01);
			if (cs_en && cs_rise) begin
				cmd_bit_r <= 3'h0;
			end else if (sclk_rise) begin
				cmd_r     <= {cmd_r[6:0], link_s.din};
				cmd_bit_r <= cmd_bit_r + 3'h1;
				if (!link_s.din || ones_cnt_r == acrc_pkg::SWRST_ONES - 7'h01) begin
					ones_cnt_r <= 7'h00;
				end else begin
					ones_cnt_r <= ones_cnt_r + 7'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_short_hold;
		DOUT_OE ##1 !DOUT_OE;
	endsequence

	sequence s_long_hold;
		DOUT_OE [*4] ##1 !DOUT_OE;
	endsequence

	sequence s_exit_taken;
		exit_p_r ##1 !ctrl_r[acrc_pkg::CTRL_CONT];
	endsequence

	a_bipolar_mid: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		conv_done && ctrl_r[acrc_pkg::CTRL_BIPOLAR] && CONV_SAMPLE == 16'h0000
		|=> result_r == acrc_pkg::CODE_MID)
		else $error("bipolar zero not mid code");

	a_unipolar_full: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		conv_done && !ctrl_r[acrc_pkg::CTRL_BIPOLAR] && CONV_SAMPLE == 16'h7fff
		|=> result_r == acrc_pkg::CODE_FULL)
		else $error("unipolar full scale not all ones");

	a_ref_output: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		$changed(ctrl_r[acrc_pkg::CTRL_REFVAL]) |=> REF_LEVEL_SEL == $past(ctrl_r[3]))
		else $error("reference select not following control");

	a_short_delay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		frame_done && !cs_en && cont_active && !abandon_pt
		&& !ctrl_r[acrc_pkg::CTRL_DDEL] |=> s_short_hold)
		else $error("short output disable delay wrong");

	a_long_delay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		frame_done && !cs_en && cont_active && !abandon_pt
		&& ctrl_r[acrc_pkg::CTRL_DDEL] |=> s_long_hold)
		else $error("long output disable delay wrong");

	a_four_wire: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		state_r == acrc_pkg::LNK_SHIFT && cs_en && frame_done
		|=> state_r == acrc_pkg::LNK_IDLE)
		else $error("delay applied in four-wire mode");

	a_ignore_clocks: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		state_r == acrc_pkg::LNK_IDLE && DRDY_N |=> state_r != acrc_pkg::LNK_SHIFT)
		else $error("frame started without data ready");

	a_abandon_late: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		state_r == acrc_pkg::LNK_SHIFT && cont_active && !(cs_en && cs_rise) && abandon_pt
		|=> state_r == acrc_pkg::LNK_IDLE ##1 DRDY_N && stat_r[acrc_pkg::EV_ABANDON])
		else $error("late transfer not abandoned");

	a_exit_command: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		cmd_byte && byte_is_exit && cont_active && !swrst_p_r |=> s_exit_taken)
		else $error("exit command not honoured");

	a_fifo_blocks: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		fifo_en_r && state_r != acrc_pkg::LNK_HOLD |=> !DOUT_OE)
		else $error("link active with buffer enabled");

	a_drdy_new: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
		conv_done |=> !DRDY_N)
		else $error("data ready not low on new result");

endmodule : acrc_top

// [testbench/acrc_host.sv]
/* Host controller model for the serial link.
 * Assumes shifting on falling and sampling on rising clock edges. */
`timescale 1ns/10ps
module acrc_host (
	output logic      sclk,
	output logic      din,
	output logic      cs_n,
	input  wire logic dout
);
	// Clock idles high between frames; select held low in 3-wire use
	initial begin
		sclk = 1'b1;
		din  = 1'b0;
		cs_n = 1'b0;
	end
	// Clocks n result bits out; the caller waits for data ready to fall
	// Pin changes are non-blocking so the block's first sync stage
	// never races the host on a shared time step
	task automatic get_word(input int n, output logic [15:0] v);
		for (int i = 0; i < n; i++) begin
			sclk <= 1'b0;
			#100 sclk <= 1'b1;
			v = {v[14:0], dout};
			#100;
		end
	endtask : get_word
	// Sends one byte without a checksum byte
	task automatic put_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			din  <= b[i];
			sclk <= 1'b0;
			#100 sclk <= 1'b1;
			#100;
		end
	endtask : put_byte
endmodule : acrc_host

// [testbench/tb_top.sv]
/* Bench for the continuous result read block.
 * Assumes a 25 ns clock and a host model on the serial pins. */
`timescale 1ns/10ps
module tb_top;
	logic        sys_clk, rst_n, av_rd, av_wr, waitreq, dout, dout_oe;
	logic        drdy_n, irq, ref_sel, ref_en, sclk, din, cs_n;
	logic [4:0]  av_addr;
	logic [31:0] av_wdata, av_rdata, rdata;
	logic [15:0] sample, word;
	logic        dout_line;   // Data line as the host sees it
	int          miscompares, checked, cycles;
	acrc_top #(.CONV_PERIOD(200)) dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
		.AVS_WRITEDATA(av_wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(av_rdata),
		.AVS_WAITREQUEST(waitreq), .CONV_SAMPLE(sample), .SCLK_PIN(sclk),
		.DIN_PIN(din), .CS_N_PIN(cs_n), .DOUT_O(dout), .DOUT_OE(dout_oe),
		.DRDY_N(drdy_n), .IRQ(irq), .REF_LEVEL_SEL(ref_sel), .INT_REF_EN(ref_en));
	// A released data line shows the inverse so a late sample is caught
	assign dout_line = dout_oe ? dout : ~dout;
	acrc_host host (.sclk(sclk), .din(din), .cs_n(cs_n), .dout(dout_line));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Hang guard: a run far past its expected length fails
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// One bus cycle held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		av_addr <= a;
		av_wr <= w;
		av_rd <= !w;
		av_wdata <= {16'h0000, d};
		do @(posedge sys_clk); while (waitreq !== 1'b0);
		rdata = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask : bus
	// One framed result read with the given control word and sample
	task automatic t_frame(input logic [15:0] ctl, input logic [15:0] s, input logic [15:0] e);
		sample <= s;
		bus(1'b1, 5'h00, ctl);
		@(negedge drdy_n);
		repeat (3) @(posedge sys_clk);
		cmp({15'h0000, irq}, 16'h0001);
		host.get_word(16, word);
		cmp(word, e);
		repeat (8) @(posedge sys_clk);
		cmp({14'h0000, drdy_n, dout_oe}, 16'h0002);
	endtask : t_frame
	// Frame left open past the abandon point; status shows the loss
	task automatic t_abandon();
		bus(1'b1, 5'h00, 16'h4800);
		@(negedge drdy_n);
		repeat (120) @(posedge sys_clk);
		host.get_word(8, word);
		repeat (20) @(posedge sys_clk);
		cmp({15'h0000, dout_oe}, 16'h0000);
		bus(1'b0, 5'h04, 16'h0000);
		cmp(rdata[15:0], 16'h0003);
	endtask : t_abandon
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial begin
		{rst_n, av_rd, av_wr, av_addr, av_wdata, sample, cycles} = '0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b0, 5'h00, 16'h0000);
		cmp(rdata[15:0], 16'h4000);
		bus(1'b0, 5'h14, 16'h0000);
		cmp(rdata[15:0], 16'h0000);
		bus(1'b1, 5'h00, 16'h4108);
		repeat (2) @(posedge sys_clk);
		cmp({14'h0000, ref_sel, ref_en}, 16'h0003);
		bus(1'b1, 5'h08, 16'h0007);
		t_frame(16'h4800, 16'h0000, 16'h8000);
		t_frame(16'h0800, 16'h7fff, 16'hffff);
		t_frame(16'h4800, 16'h8000, 16'h0000);
		t_frame(16'h4804, 16'h0000, 16'h8000);
		t_abandon();
		bus(1'b1, 5'h0c, 16'h0001);
		bus(1'b0, 5'h0c, 16'h0000);
		cmp({14'h0000, rdata[1:0]}, 16'h0001);
		bus(1'b1, 5'h0c, 16'h0000);
		host.put_byte(8'h42);
		repeat (4) @(posedge sys_clk);
		bus(1'b0, 5'h00, 16'h0000);
		cmp(rdata[15:0], 16'h4000);
		bus(1'b1, 5'h00, 16'h4108);
		repeat (8) host.put_byte(8'hff);
		repeat (4) @(posedge sys_clk);
		bus(1'b0, 5'h00, 16'h0000);
		cmp(rdata[15:0], 16'h4000);
		bus(1'b1, 5'h08, 16'h0000);
		repeat (3) @(posedge sys_clk);
		cmp({15'h0000, irq}, 16'h0000);
		tally_and_finish();
	end
endmodule : tb_top
